// >>> verilog/tpmc_pkg.sv
// constants for the t1 performance monitor counter block
package tpmc_pkg;
    localparam int NUM_LINKS = 4;
    localparam int NUM_BYTES = 16;

    // register byte offsets
    localparam logic [7:0] ACCESS_PORT_OFS = 8'h00;
    localparam logic [7:0] ACCESS_DATA_OFS = 8'h04;
    localparam logic [7:0] CONTROL_OFS     = 8'h08;
    localparam logic [7:0] FORMAT_OFS      = 8'h0C;
    localparam logic [7:0] OVF_FLAG_OFS    = 8'h10;
    localparam logic [7:0] OVF_EN_OFS      = 8'h20;
    localparam logic [7:0] LINK_BLK_MASK   = 8'hF0;

    // access port fields
    localparam int IDX_LSB = 0;
    localparam int LSEL_LSB = 4;
    // control fields
    localparam int MANUAL_BIT = 0;
    localparam int AUTO_BIT   = 1;
    // per-link format nibble: [1:0] format, [2] b8zs, [3] t1 operation
    localparam int FMT_BITS   = 4;
    localparam int B8ZS_BIT   = 2;
    localparam int T1OP_BIT   = 3;

    localparam logic [15:0] FORMAT_RST = 16'h8888;
    localparam logic [6:0]  OVF_EN_RST = 7'h00;

    typedef enum logic [1:0] {
        FMT_SF, FMT_ESF, FMT_DM, FMT_SLC96
    } tpmc_format_e;

    // indirect counter indexes
    localparam logic [3:0] IX_CRC_LO  = 4'h0;
    localparam logic [3:0] IX_CRC_HI  = 4'h1;
    localparam logic [3:0] IX_FER_LO  = 4'h2;
    localparam logic [3:0] IX_FER_HI  = 4'h3;
    localparam logic [3:0] IX_COFA    = 4'h4;
    localparam logic [3:0] IX_OOF     = 4'h5;
    localparam logic [3:0] IX_PATTERN_DETECTOR_LO = 4'h6;
    localparam logic [3:0] IX_PATTERN_DETECTOR_HI = 4'h7;
    localparam logic [3:0] IX_LCV_LO  = 4'h8;
    localparam logic [3:0] IX_LCV_HI  = 4'h9;
    localparam logic [3:0] IX_DDS_LO  = 4'hA;
    localparam logic [3:0] IX_DDS_HI  = 4'hB;

    // overflow flag bit positions
    localparam int OV_LCV  = 0;
    localparam int OV_FER  = 1;
    localparam int OV_CRC  = 2;
    localparam int OV_DDS  = 3;
    localparam int OV_COFA = 4;
    localparam int OV_OOF  = 5;
    localparam int OV_PATTERN_DETECTOR = 6;
    localparam int OV_BITS = 7;

    // counter full values
    localparam logic [15:0] MAX_LCV  = 16'hFFFF;
    localparam logic [15:0] MAX_FER  = 16'h0FFF;
    localparam logic [15:0] MAX_CRC  = 16'h03FF;
    localparam logic [15:0] MAX_DDS  = 16'h03FF;
    localparam logic [15:0] MAX_COFA = 16'h0007;
    localparam logic [15:0] MAX_OOF  = 16'h001F;
    localparam logic [15:0] MAX_PATTERN_DETECTOR = 16'hFFFF;

    // auto report period
    localparam int CLK_PERIOD_NS    = 100;
    localparam int REPORT_PERIOD_MS = 1000;
    localparam int REPORT_CYCLES    =
        REPORT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// >>> verilog/tpmc_counters.sv
// per-link performance monitor counters with indirect apb access
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps

// Summary of operation
// - each counter overflow sets its own sticky overflow flag.
// - interrupt line rises only for overflows whose enable bit is set.
// - counters are reachable only through access port and data registers.
// - link selector then counter index choose the one visible counter.
// - a report copies every counter of the selected link into a byte-indexed snapshot.
// - with auto reporting on, a report happens once every second.
// - writing the manual trigger from 0 to 1 reports at once.
// - after a report all counters of the selected link clear together.
// - events arriving during the clear count in the new round.
// - counted events depend on format; line and pattern counters always.
// - line counter takes bipolar violations in ami, code violations in b8zs.
// - framing counter takes f-bit errors, or alignment bit errors in esf.
// - crc-6 errors are counted in esf only, with own flag and enable.
// - alignment position changes are counted in every format.
// - out-of-frame events are counted in every format.
// - dm format only in t1 operation; dds errors replace crc counter.
// - slc-96 only in t1 operation; no crc or dds counting.
// - line counter sits at indexes 9/8, framing counter at 3/2.
module tpmc_counters #(
    parameter int TICK_CYCLES = tpmc_pkg::REPORT_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  bipolarViol,
    input  wire logic [3:0]  codeViol,
    input  wire logic [3:0]  fBitErr,
    input  wire logic [3:0]  alignBitErr,
    input  wire logic [3:0]  crcErr,
    input  wire logic [3:0]  ddsErr,
    input  wire logic [3:0]  alignChange,
    input  wire logic [3:0]  syncLoss,
    input  wire logic [3:0]  patternBitErr,
    output logic      [3:0]  ovfIrq
);
    localparam int NL = tpmc_pkg::NUM_LINKS;

    logic [3:0]  counterIndex_r;
    logic [1:0]  linkSelector_r;
    logic        manualUpdateTrigger_r;
    logic        autoReportEnable_r;
    logic [15:0] format_r;
    logic [6:0]  ovfFlag_r [NL];
    logic [6:0]  ovfIrqEn_r [NL];
    logic [15:0] lcv_r  [NL];
    logic [15:0] fer_r  [NL];
    logic [15:0] crc_r  [NL];
    logic [15:0] dds_r  [NL];
    logic [15:0] cofa_r [NL];
    logic [15:0] oof_r  [NL];
    logic [15:0] pattern_detector_r [NL];
    logic [7:0]  snap_r [tpmc_pkg::NUM_BYTES];
    logic [23:0] tickCnt_r;
    logic        tick;
    logic        manualPulse_r;
    logic        xfer;
    logic        wrEn;
    logic        rdSetup;
    logic        addrOk;
    logic [1:0]  blkLink;
    logic [31:0] rdData;

    // returns {overflow, next value}; a clear restarts from the event
    function automatic logic [16:0] bump(input logic [15:0] cnt,
                                         input logic [15:0] maxv,
                                         input logic        inc,
                                         input logic        clr);
        logic [15:0] base;
        base = clr ? 16'h0000 : cnt;
        if (!inc) begin
            bump = {1'b0, base};
        end else if (base == maxv) begin
            bump = {1'b1, 16'h0000};
        end else begin
            bump = {1'b0, base + 16'h0001};
        end
    endfunction

    assign pready  = 1'b1;
    assign wrEn    = psel && penable && pwrite && addrOk;
    assign rdSetup = psel && !penable && !pwrite;
    assign blkLink = paddr[3:2];

    always_comb begin
        addrOk = 1'b0;
        case (paddr & tpmc_pkg::LINK_BLK_MASK)
             8'h00:   addrOk = (paddr[1:0] == 2'b00);
            tpmc_pkg::OVF_FLAG_OFS: addrOk = (paddr[1:0] == 2'b00);
            tpmc_pkg::OVF_EN_OFS:   addrOk = (paddr[1:0] == 2'b00);
            default: addrOk = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addrOk;

    // shared one-second divider
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tickCnt_r <= 24'h000000;
        end else if (tickCnt_r == 24'(TICK_CYCLES - 1)) begin
            tickCnt_r <= 24'h000000;
        end else begin
            tickCnt_r <= tickCnt_r + 24'h000001;
        end
    end
    assign tick = (tickCnt_r == 24'(TICK_CYCLES - 1));

    assign xfer = manualPulse_r || (tick && autoReportEnable_r);

    // control registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            counterIndex_r        <= 4'h0;
            linkSelector_r        <= 2'h0;
            manualUpdateTrigger_r <= 1'b0;
            autoReportEnable_r    <= 1'b0;
            format_r              <= tpmc_pkg::FORMAT_RST;
            manualPulse_r         <= 1'b0;
        end else begin
            manualPulse_r <= 1'b0;
            if (wrEn) begin
                case (paddr)
                    tpmc_pkg::ACCESS_PORT_OFS: begin
                        counterIndex_r <= pwdata[tpmc_pkg::IDX_LSB +: 4];
                        linkSelector_r <= pwdata[tpmc_pkg::LSEL_LSB +: 2];
                    end
                    tpmc_pkg::CONTROL_OFS: begin
                        manualUpdateTrigger_r <= pwdata[tpmc_pkg::MANUAL_BIT];
                        autoReportEnable_r    <= pwdata[tpmc_pkg::AUTO_BIT];
                        manualPulse_r <= pwdata[tpmc_pkg::MANUAL_BIT]
                                         && !manualUpdateTrigger_r;
                    end
                    tpmc_pkg::FORMAT_OFS: format_r <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // event counters, one set per link
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int l = 0; l < NL; l++) begin
                lcv_r[l]  <= 16'h0000;
                fer_r[l]  <= 16'h0000;
                crc_r[l]  <= 16'h0000;
                dds_r[l]  <= 16'h0000;
                cofa_r[l] <= 16'h0000;
                oof_r[l]  <= 16'h0000;
                pattern_detector_r[l] <= 16'h0000;
            end
        end else begin
            for (int l = 0; l < NL; l++) begin
                logic [3:0] cfg;
                logic       clr;
                logic       esf;
                logic       t1op;
                logic       lInc;
                logic       fInc;
                logic [16:0] r;
                cfg  = format_r[l*tpmc_pkg::FMT_BITS +: 4];
                clr  = xfer && (linkSelector_r == 2'(l));
                esf  = (cfg[1:0] == 2'(tpmc_pkg::FMT_ESF));
                t1op = cfg[tpmc_pkg::T1OP_BIT];
                lInc = cfg[tpmc_pkg::B8ZS_BIT] ? codeViol[l]
                                               : bipolarViol[l];
                fInc = esf ? alignBitErr[l] : fBitErr[l];
                if (!t1op && cfg[1]) begin
                    fInc = 1'b0;
                end
                r = bump(lcv_r[l], tpmc_pkg::MAX_LCV, lInc, clr);
                lcv_r[l] <= r[15:0];
                r = bump(fer_r[l], tpmc_pkg::MAX_FER, fInc, clr);
                fer_r[l] <= r[15:0];
                r = bump(crc_r[l], tpmc_pkg::MAX_CRC,
                         crcErr[l] && esf, clr);
                crc_r[l] <= r[15:0];
                r = bump(dds_r[l], tpmc_pkg::MAX_DDS, ddsErr[l] && t1op
                         && cfg[1:0] == 2'(tpmc_pkg::FMT_DM), clr);
                dds_r[l] <= r[15:0];
                r = bump(cofa_r[l], tpmc_pkg::MAX_COFA,
                         alignChange[l], clr);
                cofa_r[l] <= r[15:0];
                r = bump(oof_r[l], tpmc_pkg::MAX_OOF, syncLoss[l], clr);
                oof_r[l] <= r[15:0];
                r = bump(pattern_detector_r[l], tpmc_pkg::MAX_PATTERN_DETECTOR,
                         patternBitErr[l], clr);
                pattern_detector_r[l] <= r[15:0];
            end
        end
    end

    // sticky overflow flags, set wins over write-one-to-clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int l = 0; l < NL; l++) begin
                ovfFlag_r[l]  <= 7'h00;
                ovfIrqEn_r[l] <= tpmc_pkg::OVF_EN_RST;
            end
        end else begin
            for (int l = 0; l < NL; l++) begin
                logic [3:0] cfg;
                logic       clr;
                logic       esf;
                logic       t1op;
                logic [6:0] ov;
                logic [6:0] wc;
                logic [16:0] b;
                cfg  = format_r[l*tpmc_pkg::FMT_BITS +: 4];
                clr  = xfer && (linkSelector_r == 2'(l));
                esf  = (cfg[1:0] == 2'(tpmc_pkg::FMT_ESF));
                t1op = cfg[tpmc_pkg::T1OP_BIT];
                // same increments as the counter process, so a flag
                // rises in the very cycle its counter wraps to zero
                ov = 7'h00;
                b = bump(lcv_r[l], tpmc_pkg::MAX_LCV,
                    cfg[tpmc_pkg::B8ZS_BIT] ? codeViol[l] : bipolarViol[l],
                    clr);
                ov[tpmc_pkg::OV_LCV] = b[16];
                b = bump(fer_r[l], tpmc_pkg::MAX_FER,
                    (esf ? alignBitErr[l] : fBitErr[l]) && (t1op || !cfg[1]),
                    clr);
                ov[tpmc_pkg::OV_FER] = b[16];
                b = bump(crc_r[l], tpmc_pkg::MAX_CRC,
                    crcErr[l] && esf, clr);
                ov[tpmc_pkg::OV_CRC] = b[16];
                b = bump(dds_r[l], tpmc_pkg::MAX_DDS,
                    ddsErr[l] && t1op && cfg[1:0] == 2'(tpmc_pkg::FMT_DM),
                    clr);
                ov[tpmc_pkg::OV_DDS] = b[16];
                b = bump(cofa_r[l], tpmc_pkg::MAX_COFA,
                    alignChange[l], clr);
                ov[tpmc_pkg::OV_COFA] = b[16];
                b = bump(oof_r[l], tpmc_pkg::MAX_OOF,
                    syncLoss[l], clr);
                ov[tpmc_pkg::OV_OOF] = b[16];
                b = bump(pattern_detector_r[l], tpmc_pkg::MAX_PATTERN_DETECTOR,
                    patternBitErr[l], clr);
                ov[tpmc_pkg::OV_PATTERN_DETECTOR] = b[16];
                // write-one-to-clear, applied below the set term
                wc = 7'h00;
                if (wrEn && blkLink == 2'(l) && (paddr
                        & tpmc_pkg::LINK_BLK_MASK) == tpmc_pkg::OVF_FLAG_OFS)
                begin
                    wc = pwdata[6:0];
                end
                ovfFlag_r[l] <= (ovfFlag_r[l] & ~wc) | ov;
                if (wrEn && blkLink == 2'(l) && (paddr
                        & tpmc_pkg::LINK_BLK_MASK) == tpmc_pkg::OVF_EN_OFS)
                begin
                    ovfIrqEn_r[l] <= pwdata[6:0];
                end
            end
        end
    end

    // interrupt only where enabled
    always_comb begin
        for (int l = 0; l < NL; l++) begin
            ovfIrq[l] = |(ovfFlag_r[l] & ovfIrqEn_r[l]);
        end
    end

    // snapshot of the selected link, byte-indexed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < tpmc_pkg::NUM_BYTES; i++) begin
                snap_r[i] <= 8'h00;
            end
        end else if (xfer) begin
            for (int i = 0; i < tpmc_pkg::NUM_BYTES; i++) begin
                snap_r[i] <= 8'h00;
            end
            snap_r[tpmc_pkg::IX_CRC_LO]  <= crc_r[linkSelector_r][7:0];
            snap_r[tpmc_pkg::IX_CRC_HI]  <= crc_r[linkSelector_r][15:8];
            snap_r[tpmc_pkg::IX_FER_LO]  <= fer_r[linkSelector_r][7:0];
            snap_r[tpmc_pkg::IX_FER_HI]  <= fer_r[linkSelector_r][15:8];
            snap_r[tpmc_pkg::IX_COFA]    <= cofa_r[linkSelector_r][7:0];
            snap_r[tpmc_pkg::IX_OOF]     <= oof_r[linkSelector_r][7:0];
            snap_r[tpmc_pkg::IX_PATTERN_DETECTOR_LO] <= pattern_detector_r[linkSelector_r][7:0];
            snap_r[tpmc_pkg::IX_PATTERN_DETECTOR_HI] <= pattern_detector_r[linkSelector_r][15:8];
            snap_r[tpmc_pkg::IX_LCV_LO]  <= lcv_r[linkSelector_r][7:0];
            snap_r[tpmc_pkg::IX_LCV_HI]  <= lcv_r[linkSelector_r][15:8];
            snap_r[tpmc_pkg::IX_DDS_LO]  <= dds_r[linkSelector_r][7:0];
            snap_r[tpmc_pkg::IX_DDS_HI]  <= dds_r[linkSelector_r][15:8];
        end
    end

    // read mux; counters themselves have no address
    always_comb begin
        rdData = 32'h00000000;
        case (paddr & tpmc_pkg::LINK_BLK_MASK)
            8'h00: begin
                case (paddr)
                    tpmc_pkg::ACCESS_PORT_OFS:
                        rdData = {26'h0, linkSelector_r, counterIndex_r};
                    tpmc_pkg::ACCESS_DATA_OFS:
                        rdData = {24'h0, snap_r[counterIndex_r]};
                    tpmc_pkg::CONTROL_OFS:
                        rdData = {30'h0, autoReportEnable_r,
                                  manualUpdateTrigger_r};
                    tpmc_pkg::FORMAT_OFS:
                        rdData = {16'h0, format_r};
                    default: rdData = 32'h00000000;
                endcase
            end
            tpmc_pkg::OVF_FLAG_OFS: rdData = {25'h0, ovfFlag_r[blkLink]};
            tpmc_pkg::OVF_EN_OFS:   rdData = {25'h0, ovfIrqEn_r[blkLink]};
            default: rdData = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (rdSetup) begin
            prdata <= rdData;
        end
    end
endmodule // tpmc_counters

// >>> sim/tpmc_evt_src.sv
// event source model standing in for the receive framer and line decoder
`timescale 1ns/1ps
module tpmc_evt_src (
    input  wire logic            clk_sys,
    output logic      [8:0][3:0] evt
);
    initial evt = '0;

    // one event per high cycle, on every link whose mask bit is set
    task automatic pulse(input int kind, input logic [3:0] mask,
                         input int n);
        @(posedge clk_sys);
        repeat (n) begin
            evt[kind] <= mask;
            @(posedge clk_sys);
        end
        evt[kind] <= 4'h0;
    endtask
endmodule // tpmc_evt_src

// >>> sim/tpmc_counters_chk.sv
// port checker for the performance monitor counter block
`timescale 1ns/1ps
module tpmc_counters_chk #(
    parameter int TICK_CYCLES = 50
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  ovfIrq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_READY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_ERR_ACCESS_ONLY: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    AST_UNMAPPED_ERR: assert property (
        psel && penable && paddr >= 8'h30 |-> pslverr)
        else $error("unmapped address not refused");
    AST_MISALIGNED_ERR: assert property (
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned address not refused");
    AST_MAPPED_OK: assert property (psel && penable && paddr < 8'h30
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped address refused");
    AST_REFUSED_READ_ZERO: assert property (
        psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_RDATA_HOLD: assert property (
        $changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data changed outside a read setup");
    AST_IRQ_STICKY: assert property (
        ($past(ovfIrq) & ~ovfIrq) != 4'h0
        |-> $past(psel && penable && pwrite))
        else $error("overflow irq dropped without a write");

    cover property ($rose(ovfIrq[0]));
    cover property (pslverr);
    cover property (psel && penable && !pwrite && paddr == 8'h04);
endmodule // tpmc_counters_chk

bind tpmc_counters tpmc_counters_chk #(.TICK_CYCLES(TICK_CYCLES))
    tpmc_counters_chk_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ovfIrq(ovfIrq));

// >>> sim/tpmc_counters_tb_top.sv
// testbench for the performance monitor counter block
`timescale 1ns/1ps
module tpmc_counters_tb_top;
    localparam int TICK = 50;
    logic            clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rdata;
    logic            err;
    logic [3:0]      ovfIrq;
    logic [8:0][3:0] evt;
    logic [1:0]      curLink;
    logic [7:0]      v1;
    int              failCount, samplesChecked, seen;

    tpmc_counters #(.TICK_CYCLES(TICK)) tpmc_counters_i (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ovfIrq(ovfIrq),
        .bipolarViol(evt[0]), .codeViol(evt[1]), .fBitErr(evt[2]),
        .alignBitErr(evt[3]), .crcErr(evt[4]), .ddsErr(evt[5]),
        .alignChange(evt[6]), .syncLoss(evt[7]), .patternBitErr(evt[8]));
    tpmc_evt_src tpmc_evt_src_i (.clk_sys(clk_sys), .evt(evt));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic finalReport;
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 20) begin
            failCount++;
            finalReport;
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    // select a counter byte of the current snapshot and read it
    task automatic byteChk(input logic [3:0] idx, input logic [7:0] exp);
        apb(1'b1, 8'h00, {26'h0, curLink, idx});
        rdChk(8'h04, {24'h0, exp});
    endtask

    task automatic trig;
        apb(1'b1, 8'h00, {26'h0, curLink, 4'h0});
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h08, 32'h1);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        failCount++;
        finalReport;
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        failCount = 0;
        samplesChecked = 0;
        rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rdChk(8'h0C, 32'h8888);
        rdChk(8'h20, 32'h0);
        rdChk(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h02, 32'hFF);
        chk({31'h0, err}, 32'h1);
        $display("test reset_and_map done");
        // link l runs format l; b8zs on links 1 and 3
        apb(1'b1, 8'h0C, 32'hFAD8);
        for (int k = 0; k < 9; k++) tpmc_evt_src_i.pulse(k, 4'hF, k + 1);
        for (int l = 0; l < 4; l++) begin
            curLink = l[1:0];
            trig;
            byteChk(4'h8, l[0] ? 8'h02 : 8'h01);
            byteChk(4'h9, 8'h00);
            byteChk(4'h2, l == 1 ? 8'h04 : 8'h03);
            byteChk(4'h3, 8'h00);
            byteChk(4'h0, l == 1 ? 8'h05 : 8'h00);
            byteChk(4'hA, l == 2 ? 8'h06 : 8'h00);
            byteChk(4'h4, 8'h07);
            byteChk(4'h5, 8'h08);
            byteChk(4'h6, 8'h09);
            byteChk(4'hF, 8'h00);
            trig;
            byteChk(4'h6, 8'h00);
        end
        $display("test formats done");
        curLink = 2'h0;
        tpmc_evt_src_i.pulse(6, 4'h1, 9);
        tpmc_evt_src_i.pulse(8, 4'h1, 300);
        rdChk(8'h10, 32'h10);
        chk({28'h0, ovfIrq}, 32'h0);
        apb(1'b1, 8'h20, 32'h10);
        @(negedge clk_sys);
        chk({28'h0, ovfIrq}, 32'h1);
        trig;
        byteChk(4'h4, 8'h01);
        byteChk(4'h6, 8'h2C);
        byteChk(4'h7, 8'h01);
        rdChk(8'h10, 32'h10);
        apb(1'b1, 8'h10, 32'h10);
        @(negedge clk_sys);
        chk({28'h0, ovfIrq}, 32'h0);
        rdChk(8'h10, 32'h0);
        $display("test overflow done");
        curLink = 2'h1;
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b1, 8'h08, 32'h0);
        fork
            apb(1'b1, 8'h08, 32'h1);
            tpmc_evt_src_i.pulse(8, 4'h2, 6);
        join
        byteChk(4'h6, 8'h02);
        apb(1'b1, 8'h00, 32'h16);
        apb(1'b0, 8'h04, 32'h0);
        v1 = rdata[7:0];
        trig;
        apb(1'b1, 8'h00, 32'h16);
        apb(1'b0, 8'h04, 32'h0);
        chk({24'h0, v1 + rdata[7:0]}, 32'h6);
        $display("test clear_race done");
        curLink = 2'h3;
        tpmc_evt_src_i.pulse(7, 4'h8, 3);
        apb(1'b1, 8'h00, 32'h35);
        apb(1'b1, 8'h08, 32'h2);
        seen = 0;
        repeat (40) begin
            apb(1'b0, 8'h04, 32'h0);
            if (rdata === 32'h3) seen = 1;
        end
        chk(seen, 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        $display("test auto_report done");
        finalReport;
    end
endmodule // tpmc_counters_tb_top
